// *** rtl/tmss_pkg.sv ***
// package: constants and types of the timing mode select and status block
package tmss_pkg;

  // clock and time figures
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned HIST_SECONDS   = 40;
  localparam int unsigned SAMPLE_TIME_NS = 1000000000;
  localparam int unsigned SAMPLE_CYCLES  = SAMPLE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LOSS_TIME_NS   = 250000;
  localparam int unsigned LOSS_CYCLES    = LOSS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_EDGES     = 16;
  localparam int unsigned LOCK_TOL       = 2;

  // register offsets (byte addresses)
  localparam logic [11:0] ADDR_STATUS   = 12'h000;
  localparam logic [11:0] ADDR_NOMINAL  = 12'h004;
  localparam logic [11:0] ADDR_TRACKED  = 12'h008;
  localparam logic [11:0] ADDR_HOLDOVER = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;

  // decoded register index
  localparam logic [2:0] REG_STATUS   = 3'h0;
  localparam logic [2:0] REG_NOMINAL  = 3'h1;
  localparam logic [2:0] REG_TRACKED  = 3'h2;
  localparam logic [2:0] REG_HOLDOVER = 3'h3;
  localparam logic [2:0] REG_IRQ_STAT = 3'h4;
  localparam logic [2:0] REG_IRQ_MASK = 3'h5;
  localparam logic [2:0] REG_NONE     = 3'h7;

  // reset values: free-run output period of 8 kHz in clock cycles
  localparam logic [23:0] NOMINAL_RESET  = 24'h001388;
  localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

  typedef enum logic [3:0] {
    ST_FREE_RUN = 4'b0001,
    ST_REF_ONE  = 4'b0010,
    ST_REF_TWO  = 4'b0100,
    ST_HOLDOVER = 4'b1000
  } tmss_state_type;

  typedef struct packed {
    logic alarm_rise;
    logic lock_fail;
    logic input_loss;
    logic mode_change;
  } tmss_evt_type;

endpackage : tmss_pkg

// *** rtl/tmss_top.sv ***
// module: mode select, reference supervision, holdover history and status
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE1) no valid select: free run, alarm on
// (RULE2) A high B low: lock to input one
// (RULE3) A low B high: lock to input two
// (RULE4) both high: holdover at stored locked frequency
// (RULE5) both low: free run from internal oscillator
// (RULE6) alarm in holdover and free run
// (RULE7) alarm on lock loss or reference loss
// (RULE8) alarm output is active high
// (RULE9) four one-hot mode indicators, always driven
// (RULE10) keep forty-second filtered locked frequency history
// (RULE11) indicator high only in its own mode
// (RULE12) lock-lost flag shows loop not locked
// (RULE13) float input high disables output drive
// (RULE14) reference loss: holdover indicator and alarm
module tmss_top #(
  parameter int unsigned PERIOD_W        = 24,
  parameter int unsigned HIST_DEPTH      = tmss_pkg::HIST_SECONDS,
  parameter int unsigned SAMPLE_CYCLES_P = tmss_pkg::SAMPLE_CYCLES,
  parameter int unsigned LOSS_CYCLES_P   = tmss_pkg::LOSS_CYCLES
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output var  logic [31:0] PRDATA_O,
  output var  logic        PREADY_O,
  output var  logic        PSLVERR_O,
  input  wire logic        MODE_SELECT_A_I,
  input  wire logic        MODE_SELECT_B_I,
  input  wire logic        EXTERNAL_INPUT_ONE_I,
  input  wire logic        EXTERNAL_INPUT_TWO_I,
  input  wire logic        OUTPUT_FLOAT_I,
  output var  logic        IND_REF_ONE_O,
  output var  logic        IND_REF_TWO_O,
  output var  logic        IND_HOLDOVER_O,
  output var  logic        IND_FREE_RUN_O,
  output var  logic        ALARM_O,
  output var  logic        LOCK_LOST_O,
  output var  logic        SYNC_OUT_O,
  output var  logic        SYNC_OUT_OE_O,
  output var  logic        IRQ_O
);
  import tmss_pkg::*;
  localparam int unsigned SUM_W = PERIOD_W + 6;
  function automatic logic [2:0] reg_decode(input logic [11:0] addr);
    logic [2:0] idx;
    idx = REG_NONE;
    if (addr == ADDR_STATUS) idx = REG_STATUS;
    else if (addr == ADDR_NOMINAL) idx = REG_NOMINAL;
    else if (addr == ADDR_TRACKED) idx = REG_TRACKED;
    else if (addr == ADDR_HOLDOVER) idx = REG_HOLDOVER;
    else if (addr == ADDR_IRQ_STAT) idx = REG_IRQ_STAT;
    else if (addr == ADDR_IRQ_MASK) idx = REG_IRQ_MASK;
    return idx;
  endfunction : reg_decode
  function automatic logic in_tol(input logic [PERIOD_W-1:0] a,
                                  input logic [PERIOD_W-1:0] b);
    logic [PERIOD_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= PERIOD_W'(LOCK_TOL);
  endfunction : in_tol

  ////////////////////////////////////////////////////////////////////////
  // reference selection and edge detection
  logic                ref_one_q;
  logic                ref_two_q;
  logic                sel_one;
  logic                sel_two;
  logic                ref_mode;
  logic                sel_edge;
  logic [1:0]          sel_prev;
  logic                sel_change;
  logic [PERIOD_W-1:0] since_edge;
  logic [PERIOD_W-1:0] meas;
  logic [PERIOD_W-1:0] tracked;
  logic [4:0]          lock_count;
  logic                locked;
  logic                loss;
  logic                next_loss;
  assign sel_one    = MODE_SELECT_A_I & ~MODE_SELECT_B_I;
  assign sel_two    = ~MODE_SELECT_A_I & MODE_SELECT_B_I;
  assign ref_mode   = sel_one | sel_two;
  assign sel_change = ({sel_two, sel_one} != sel_prev);
  assign sel_edge   = (sel_one & EXTERNAL_INPUT_ONE_I & ~ref_one_q)
                    | (sel_two & EXTERNAL_INPUT_TWO_I & ~ref_two_q);
  assign meas       = since_edge + PERIOD_W'(1);
  // selected reference silent for too long
  assign next_loss  = ref_mode & ~sel_change & ~sel_edge
                    & (since_edge >= PERIOD_W'(LOSS_CYCLES_P)); // RULE7
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ref_one_q <= 1'b0;
      ref_two_q <= 1'b0;
      sel_prev  <= 2'h0;
    end else begin
      ref_one_q <= EXTERNAL_INPUT_ONE_I;
      ref_two_q <= EXTERNAL_INPUT_TWO_I;
      sel_prev  <= {sel_two, sel_one};
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      since_edge <= '0;
      loss       <= 1'b0;
    end else begin
      loss <= next_loss;
      if (sel_change || sel_edge || !ref_mode) begin
        since_edge <= '0;
      end else if (since_edge != '1) begin
        since_edge <= since_edge + PERIOD_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // period tracking filter and lock detection
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tracked    <= NOMINAL_RESET[PERIOD_W-1:0];
      lock_count <= 5'h00;
      locked     <= 1'b0;
    end else if (sel_change || !ref_mode || next_loss) begin
      lock_count <= 5'h00;
      locked     <= 1'b0;
    end else if (sel_edge) begin
      tracked <= PERIOD_W'(({1'b0, tracked} + {1'b0, meas}) >> 1);
      if (in_tol(meas, tracked)) begin
        if (lock_count == 5'(LOCK_EDGES)) begin
          locked <= 1'b1;
        end else begin
          lock_count <= lock_count + 5'h01;
        end
      end else begin
        lock_count <= 5'h00;
        locked     <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating state and indicators
  tmss_state_type state;
  tmss_state_type next_state;
  logic           next_lock_lost;
  logic           next_alarm;
  always_comb begin
    next_state = ST_FREE_RUN; // RULE1
    case ({MODE_SELECT_A_I, MODE_SELECT_B_I})
      2'b10: begin
        next_state = next_loss ? ST_HOLDOVER : ST_REF_ONE; // RULE2 RULE14
      end
      2'b01: begin
        next_state = next_loss ? ST_HOLDOVER : ST_REF_TWO; // RULE3 RULE14
      end
      2'b11:   next_state = ST_HOLDOVER; // RULE4
      default: next_state = ST_FREE_RUN; // RULE5
    endcase
  end
  // unlocked while tracking a reference that is present
  assign next_lock_lost = ref_mode & ~next_loss
                        & ~(locked & ~sel_change); // RULE12
  assign next_alarm = (next_state == ST_FREE_RUN)
                    | (next_state == ST_HOLDOVER) // RULE6 RULE14
                    | next_lock_lost | next_loss; // RULE7
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state       <= ST_FREE_RUN; // RULE1
      ALARM_O     <= 1'b1; // RULE1 RULE8
      LOCK_LOST_O <= 1'b0;
    end else begin
      state       <= next_state;
      ALARM_O     <= next_alarm; // RULE8
      LOCK_LOST_O <= next_lock_lost; // RULE12
    end
  end
  // one-hot state bits are the indicator flip-flops
  assign IND_FREE_RUN_O = state[0]; // RULE9 RULE11
  assign IND_REF_ONE_O  = state[1]; // RULE9 RULE11
  assign IND_REF_TWO_O  = state[2]; // RULE9 RULE11
  assign IND_HOLDOVER_O = state[3]; // RULE9 RULE11

  ////////////////////////////////////////////////////////////////////////
  // holdover history: one locked sample per second, averaged
  logic [PERIOD_W-1:0] hist [HIST_DEPTH];
  logic [31:0]         sample_cnt;
  logic [5:0]          wr_ptr;
  logic [5:0]          fill;
  logic [SUM_W-1:0]    sum;
  logic [SUM_W-1:0]    next_sum;
  logic [PERIOD_W-1:0] holdover;
  logic                sample_tick;
  logic                sample_ok;
  assign sample_tick = (sample_cnt == SAMPLE_CYCLES_P - 1);
  assign sample_ok   = sample_tick & locked & ~next_loss
                     & ((state == ST_REF_ONE) | (state == ST_REF_TWO));
  assign next_sum = (fill == 6'(HIST_DEPTH))
                  ? sum + SUM_W'(tracked) - SUM_W'(hist[wr_ptr])
                  : sum + SUM_W'(tracked);
  always_ff @(posedge CLK_SYS_I) begin
    if (sample_ok) hist[wr_ptr] <= tracked; // RULE10
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sample_cnt <= 32'h0000_0000;
      wr_ptr     <= 6'h00;
      fill       <= 6'h00;
      sum        <= '0;
      holdover   <= NOMINAL_RESET[PERIOD_W-1:0];
    end else begin
      sample_cnt <= sample_tick ? 32'h0000_0000 : sample_cnt + 32'h1;
      if (sample_ok) begin
        sum    <= next_sum; // RULE10
        wr_ptr <= (wr_ptr == 6'(HIST_DEPTH - 1)) ? 6'h00 : wr_ptr + 6'h01;
        if (fill != 6'(HIST_DEPTH)) begin
          fill <= fill + 6'h01;
        end
        // history not yet full: latest locked period stands in
        holdover <= (fill == 6'(HIST_DEPTH))
                  ? PERIOD_W'(next_sum / SUM_W'(HIST_DEPTH))
                  : tracked; // RULE4 RULE10
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output synthesis from the period of the current mode
  logic [PERIOD_W-1:0] nominal;
  logic [PERIOD_W-1:0] out_period;
  logic [PERIOD_W-1:0] half_cnt;
  always_comb begin
    case (state)
      ST_REF_ONE, ST_REF_TWO: out_period = tracked; // RULE2 RULE3
      ST_HOLDOVER:            out_period = holdover; // RULE4
      default:                out_period = nominal; // RULE5
    endcase
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      half_cnt      <= '0;
      SYNC_OUT_O    <= 1'b0;
      SYNC_OUT_OE_O <= 1'b0;
    end else begin
      SYNC_OUT_OE_O <= ~OUTPUT_FLOAT_I; // RULE13
      if (half_cnt + PERIOD_W'(1) >= (out_period >> 1)) begin
        half_cnt   <= '0;
        SYNC_OUT_O <= ~SYNC_OUT_O;
      end else begin
        half_cnt <= half_cnt + PERIOD_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, event capture and interrupt
  tmss_evt_type evt;
  logic [3:0]   irq_stat;
  logic [3:0]   irq_mask;
  logic [3:0]   next_irq_stat;
  logic [3:0]   rd_clear;
  logic [2:0]   rd_sel;
  logic [31:0]  rd_word;
  logic         wr_done;
  logic         rd_done;
  assign evt.mode_change = (next_state != state);
  assign evt.input_loss  = next_loss & ~loss;
  assign evt.lock_fail   = next_lock_lost & ~LOCK_LOST_O;
  assign evt.alarm_rise  = next_alarm & ~ALARM_O;
  assign rd_sel  = reg_decode(PADDR_I);
  assign wr_done = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign rd_done = PSEL_I & PENABLE_I & PREADY_O & ~PWRITE_I;
  // only bits already returned are cleared; a new event still sets
  assign rd_clear = (rd_done && rd_sel == REG_IRQ_STAT)
                  ? PRDATA_O[3:0] : 4'h0;
  assign next_irq_stat = (irq_stat & ~rd_clear) | evt;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_sel == REG_STATUS) begin
      rd_word = {25'h0000000, loss, LOCK_LOST_O, ALARM_O, state};
    end else if (rd_sel == REG_NOMINAL) begin
      rd_word = 32'(nominal);
    end else if (rd_sel == REG_TRACKED) begin
      rd_word = 32'(tracked);
    end else if (rd_sel == REG_HOLDOVER) begin
      rd_word = 32'(holdover);
    end else if (rd_sel == REG_IRQ_STAT) begin
      rd_word = {28'h0000000, irq_stat};
    end else if (rd_sel == REG_IRQ_MASK) begin
      rd_word = {28'h0000000, irq_mask};
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      // ready is raised at the setup edge: no wait states
      PREADY_O <= PSEL_I & ~PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
        PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_word;
        PSLVERR_O <= (rd_sel == REG_NONE);
      end else if (PSEL_I && PENABLE_I && PREADY_O) begin
        PRDATA_O  <= 32'h0000_0000;
        PSLVERR_O <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nominal  <= NOMINAL_RESET[PERIOD_W-1:0];
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_done) begin
      if (rd_sel == REG_NOMINAL) nominal <= PWDATA_I[PERIOD_W-1:0];
      else if (rd_sel == REG_IRQ_MASK) irq_mask <= PWDATA_I[3:0];
    end
  end
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      irq_stat <= 4'h0;
      IRQ_O    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      IRQ_O    <= |(next_irq_stat & irq_mask);
    end
  end
endmodule : tmss_top
`default_nettype wire

// *** sim/tmss_monitor.sv ***
// checker: port-level assertions of the mode select and status block
`timescale 1ns/1ps
`default_nettype none

module tmss_monitor (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic MODE_SELECT_A_I,
  input wire logic MODE_SELECT_B_I,
  input wire logic OUTPUT_FLOAT_I,
  input wire logic IND_REF_ONE_O,
  input wire logic IND_REF_TWO_O,
  input wire logic IND_HOLDOVER_O,
  input wire logic IND_FREE_RUN_O,
  input wire logic ALARM_O,
  input wire logic LOCK_LOST_O,
  input wire logic SYNC_OUT_OE_O,
  input wire logic PREADY_O
);
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  ////////////////////////////////////////////////////////////////////////////
  onehot_ind_a :
    assert property ($onehot({IND_REF_ONE_O, IND_REF_TWO_O,
                              IND_HOLDOVER_O, IND_FREE_RUN_O}))
    else $error("mode indicators not one-hot");
  free_run_sel_a :
    assert property (!MODE_SELECT_A_I && !MODE_SELECT_B_I |=> IND_FREE_RUN_O)
    else $error("free run not shown for select 00");
  holdover_sel_a :
    assert property (MODE_SELECT_A_I && MODE_SELECT_B_I |=> IND_HOLDOVER_O)
    else $error("holdover not shown for select 11");
  ref_one_sel_a :
    assert property (MODE_SELECT_A_I && !MODE_SELECT_B_I
                     |=> IND_REF_ONE_O || IND_HOLDOVER_O)
    else $error("wrong state for select 10");
  ref_two_sel_a :
    assert property (!MODE_SELECT_A_I && MODE_SELECT_B_I
                     |=> IND_REF_TWO_O || IND_HOLDOVER_O)
    else $error("wrong state for select 01");
  alarm_mode_a :
    assert property (IND_HOLDOVER_O || IND_FREE_RUN_O |-> ALARM_O)
    else $error("alarm low in holdover or free run");
  lock_alarm_a :
    assert property (LOCK_LOST_O
                     |-> ALARM_O && (IND_REF_ONE_O || IND_REF_TWO_O))
    else $error("lock flag without alarm or outside reference mode");
  alarm_quiet_a :
    assert property (!ALARM_O
                     |-> (IND_REF_ONE_O || IND_REF_TWO_O) && !LOCK_LOST_O)
    else $error("alarm low while not locked to a reference");
  float_oe_a :
    assert property ($past(RESET_N_I) |-> SYNC_OUT_OE_O == !$past(OUTPUT_FLOAT_I))
    else $error("output enable does not follow float input");
  ready_pulse_a :
    assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
endmodule : tmss_monitor

bind tmss_top tmss_monitor mon_u (
  .CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
  .MODE_SELECT_A_I(MODE_SELECT_A_I), .MODE_SELECT_B_I(MODE_SELECT_B_I),
  .OUTPUT_FLOAT_I(OUTPUT_FLOAT_I), .IND_REF_ONE_O(IND_REF_ONE_O),
  .IND_REF_TWO_O(IND_REF_TWO_O), .IND_HOLDOVER_O(IND_HOLDOVER_O),
  .IND_FREE_RUN_O(IND_FREE_RUN_O), .ALARM_O(ALARM_O),
  .LOCK_LOST_O(LOCK_LOST_O), .SYNC_OUT_OE_O(SYNC_OUT_OE_O),
  .PREADY_O(PREADY_O));

`default_nettype wire

// *** sim/tmss_host_model.sv ***
// partner: host logic driving mode selects and two reference clocks
`timescale 1ns/1ps
`default_nettype none

module tmss_host_model #(
  parameter int unsigned REF_PERIOD = 20
) (
  input  wire logic       clk_i,
  input  wire logic [1:0] sel_code_i,
  input  wire logic       run_one_i,
  input  wire logic       run_two_i,
  output var  logic       select_a_o,
  output var  logic       select_b_o,
  output var  logic       ref_one_o,
  output var  logic       ref_two_o
);
  logic [7:0] phase = 8'h00;

  // code is {a, b}: 10 ref one, 01 ref two, 11 holdover, 00 free run
  assign select_a_o = sel_code_i[1];
  assign select_b_o = sel_code_i[0];

  // stopped reference sits low, which the block sees as loss
  always_ff @(posedge clk_i) begin
    phase     <= (phase == REF_PERIOD - 1) ? 8'h00 : phase + 8'h01;
    ref_one_o <= run_one_i && (phase < REF_PERIOD / 2);
    ref_two_o <= run_two_i && (phase < REF_PERIOD / 2);
  end
endmodule : tmss_host_model

`default_nettype wire

// *** sim/timing_mode_select_status_bench.sv ***
// testbench: mode select, lock, loss, interrupt and float behaviour
`timescale 1ns/1ps
`default_nettype none

module timing_mode_select_status_bench;
  import tmss_pkg::*;
  localparam int unsigned LOSS_P = 200;
  localparam logic [1:0] CODES [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  localparam logic [3:0] STATES [4] = '{ST_FREE_RUN, ST_REF_ONE,
                                        ST_REF_TWO, ST_HOLDOVER};
  logic        clk_sys = 1'b0;
  logic        reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sel_a, sel_b, ref_one, ref_two, out_float, run_one, run_two;
  logic [1:0]  sel_code;
  logic        ind_one, ind_two, ind_hold, ind_free, alarm, lock_lost;
  logic        sync_out, sync_oe, irq;
  int          miscompares, compares;

  always #12.5 clk_sys = ~clk_sys;

  tmss_top #(.SAMPLE_CYCLES_P(64), .LOSS_CYCLES_P(LOSS_P)) dut_u (
    .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .MODE_SELECT_A_I(sel_a), .MODE_SELECT_B_I(sel_b),
    .EXTERNAL_INPUT_ONE_I(ref_one), .EXTERNAL_INPUT_TWO_I(ref_two),
    .OUTPUT_FLOAT_I(out_float), .IND_REF_ONE_O(ind_one),
    .IND_REF_TWO_O(ind_two), .IND_HOLDOVER_O(ind_hold),
    .IND_FREE_RUN_O(ind_free), .ALARM_O(alarm), .LOCK_LOST_O(lock_lost),
    .SYNC_OUT_O(sync_out), .SYNC_OUT_OE_O(sync_oe), .IRQ_O(irq));

  tmss_host_model #(.REF_PERIOD(20)) host_u (
    .clk_i(clk_sys), .sel_code_i(sel_code), .run_one_i(run_one),
    .run_two_i(run_two), .select_a_o(sel_a), .select_b_o(sel_b),
    .ref_one_o(ref_one), .ref_two_o(ref_two));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task chk_bit(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit

  function automatic logic [31:0] ivec();
    return {28'h0, ind_hold, ind_two, ind_one, ind_free};
  endfunction : ivec

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task set_mode(input logic [1:0] code);
    @(posedge clk_sys);
    sel_code <= code;
    repeat (3) @(posedge clk_sys);
  endtask : set_mode

  ////////////////////////////////////////////////////////////////////////////
  task test_reset;
    chk(ivec(), {28'h0, ST_FREE_RUN}, "reset state");
    chk_bit(alarm, 1'b1, "reset alarm");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h00000011, "status at reset");
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h00000011, "status read-only");
    apb(1'b0, ADDR_NOMINAL, 32'h0);
    chk(rd, {8'h00, NOMINAL_RESET}, "nominal reset");
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(rd, 32'h00000000, "mask reset");
    apb(1'b0, 12'h020, 32'h0);
    chk_bit(err, 1'b1, "unmapped error");
    chk(rd, 32'h00000000, "unmapped data");
    $display("test_reset done");
  endtask : test_reset

  task test_modes;
    for (int i = 0; i < 4; i++) begin
      set_mode(CODES[i]);
      chk(ivec(), {28'h0, STATES[i]}, "mode indicators");
      chk_bit(alarm, 1'b1, "alarm unlocked");
      chk_bit(lock_lost, i == 1 || i == 2, "lock flag");
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({28'h0, rd[3:0]}, {28'h0, STATES[i]}, "status state");
    end
    $display("test_modes done");
  endtask : test_modes

  task test_lock;
    int n;
    set_mode(2'b10);
    n = 0;
    while (lock_lost !== 1'b0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (300) @(posedge clk_sys);
    chk(ivec(), {28'h0, ST_REF_ONE}, "locked state");
    chk_bit(alarm, 1'b0, "locked alarm");
    apb(1'b0, ADDR_TRACKED, 32'h0);
    chk(rd, 32'h00000014, "tracked period");
    @(posedge clk_sys);
    run_one <= 1'b0;
    repeat (150) @(posedge clk_sys);
    chk(ivec(), {28'h0, ST_REF_ONE}, "before loss");
    repeat (LOSS_P - 70) @(posedge clk_sys);
    chk(ivec(), {28'h0, ST_HOLDOVER}, "loss state");
    chk_bit(alarm, 1'b1, "loss alarm");
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h00000058, "loss status");
    apb(1'b0, ADDR_HOLDOVER, 32'h0);
    chk(rd, 32'h00000014, "holdover period");
    run_one <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk(ivec(), {28'h0, ST_REF_ONE}, "reference back");
    $display("test_lock done");
  endtask : test_lock

  task test_irq;
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000001);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk_bit(irq, 1'b0, "irq cleared");
    set_mode(2'b00);
    chk_bit(irq, 1'b1, "irq on mode change");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h00000001, "mode change bit");
    repeat (2) @(posedge clk_sys);
    chk_bit(irq, 1'b0, "irq after read");
    apb(1'b1, ADDR_IRQ_MASK, 32'h00000000);
    set_mode(2'b10);
    chk_bit(irq, 1'b0, "irq masked");
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, rd[0]}, 32'h00000001, "sticky while masked");
    $display("test_irq done");
  endtask : test_irq

  task test_float;
    int   toggles;
    logic prev_out;
    set_mode(2'b00);
    apb(1'b1, ADDR_NOMINAL, 32'h00000010);
    apb(1'b0, ADDR_NOMINAL, 32'h0);
    chk(rd, 32'h00000010, "nominal write");
    repeat (16) @(posedge clk_sys);
    toggles = 0;
    prev_out = sync_out;
    repeat (64) begin
      @(posedge clk_sys);
      if (sync_out !== prev_out) toggles++;
      prev_out = sync_out;
    end
    chk(toggles, 8, "free-run half periods");
    out_float <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk_bit(sync_oe, 1'b0, "float drive off");
    out_float <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk_bit(sync_oe, 1'b1, "normal drive");
    $display("test_float done");
  endtask : test_float

  task close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    close_out;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sel_code, out_float} = '0;
    {run_one, run_two} = 2'b11;
    miscompares = 0;
    compares = 0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    test_reset;
    test_modes;
    test_lock;
    test_irq;
    test_float;
    close_out;
  end
endmodule : timing_mode_select_status_bench

`default_nettype wire
